// file: verilog/fper_seq.sv
// Program and erase sequencer for the second flash array
`timescale 1ns/1ps
module fper_seq
   import fper_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic arrWr,
   input wire logic [15:0] arrAddr,
   input wire logic [7:0] arrWdata,
   input wire logic waitMode,
   input wire logic stopMode,
   output logic aHighVolt,
   output logic aWrite,
   output logic aWipe,
   output logic aWhole,
   output logic [15:0] aAddr,
   output logic [7:0] aData,
   output logic aStrobe,
   output logic rowFail
);
   // Control bits
   logic writeSel_q;
   logic wipeSel_q;
   logic wholeSel_q;
   logic hvOn_q;
   // Protect register value
   logic [7:0] prot_q;
   // Sequencer state
   fper_state_t state_q;
   fper_state_t state_d;
   // Latched row or page address
   logic [15:0] latAddr_q;
   // Protect register read seen since select set
   logic protRead_q;
   // Row failure flag
   logic rowFail_q;
   // Read data register
   logic [7:0] rdata_q;
   // Array output registers
   logic [15:0] aAddr_q;
   logic [7:0] aData_q;
   logic aStrobe_q;
   // Derived decodes
   logic ctrlWr;
   logic protRd;
   logic inArray;
   logic lowPower;
   logic selActive;
   logic [15:0] protStart;
   logic latProt;
   logic sameRow;
   logic hvReq;
   fper_row_if rowBus ();

   // Register port decode
   assign ctrlWr = regWr && regAddr == REG_CTRL;
   assign protRd = regRd && regAddr == REG_PROT;
   assign inArray = arrAddr >= ARRAY_LO && arrAddr <= ARRAY_END;
   assign lowPower = waitMode || stopMode;
   assign selActive = writeSel_q || wipeSel_q;
   // Protection start from protect bits
   assign protStart = {1'b0, prot_q, 7'h00};
   assign latProt = prot_q != PROT_RESET && latAddr_q >= protStart;
   assign sameRow = arrAddr[15:ROW_SHIFT] == latAddr_q[15:ROW_SHIFT];
   assign hvReq = ctrlWr && regWdata[CTRL_HV] && !hvOn_q;

   // Next state of the sequencer
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (selActive && !lowPower)
               state_d = ST_ARMED;
         end
         ST_ARMED:
         begin
            // Latch address on first array write after protect read
            if (!selActive)
               state_d = ST_IDLE;
            else if (lowPower)
               state_d = ST_STANDBY;
            else if (arrWr && inArray && protRead_q)
               state_d = ST_LATCHED;
         end
         ST_LATCHED:
         begin
            if (!selActive)
               state_d = ST_IDLE;
            else if (lowPower)
               state_d = ST_STANDBY;
            else if (hvReq && !latProt)
               state_d = ST_HIGHV;
         end
         ST_HIGHV:
         begin
            if (lowPower)
               state_d = ST_STANDBY;
            else if (!hvOn_q && !selActive)
               state_d = ST_IDLE;
         end
         ST_STANDBY:
         begin
            // Stay suspended until software drops the selects and the high voltage bit
            if (!selActive && !hvOn_q)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Control bits with interlock and high voltage gating
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         writeSel_q <= 1'b0;
         wipeSel_q <= 1'b0;
         wholeSel_q <= 1'b0;
         hvOn_q <= 1'b0;
      end
      else if (ctrlWr)
      begin
         // Select refused if other select already set
         writeSel_q <= regWdata[CTRL_WRITE] && !wipeSel_q
            && !(regWdata[CTRL_WIPE] && !writeSel_q);
         wipeSel_q <= regWdata[CTRL_WIPE] && !writeSel_q;
         wholeSel_q <= regWdata[CTRL_WHOLE];
         if (!regWdata[CTRL_HV])
            hvOn_q <= 1'b0;
         else if (state_q == ST_LATCHED && !latProt && !lowPower)
            hvOn_q <= 1'b1;
      end
   end

   // Protect register read tracking
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         protRead_q <= 1'b0;
      else if (!selActive)
         protRead_q <= 1'b0;
      else if (protRd)
         protRead_q <= 1'b1;
   end

   // Protect register, written by the other array's programming path
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         prot_q <= PROT_RESET;
      else if (regWr && regAddr == REG_PROT && state_q == ST_IDLE)
         prot_q <= regWdata;
   end

   // Row or page address latch
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         latAddr_q <= 16'h0000;
      else if (state_q == ST_ARMED && state_d == ST_LATCHED)
         latAddr_q <= arrAddr;
   end

   // Row failure: byte write outside the latched row
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rowFail_q <= 1'b0;
      else if (state_q == ST_HIGHV && writeSel_q && arrWr && !sameRow)
         rowFail_q <= 1'b1;
      else if (state_q == ST_ARMED && state_d == ST_LATCHED)
         rowFail_q <= 1'b0;
   end

   // Row latch write port
   assign rowBus.wrEn = state_q == ST_HIGHV && writeSel_q && arrWr
      && sameRow && !rowFail_q && !lowPower;
   assign rowBus.wrIdx = arrAddr[ROW_AW-1:0];
   assign rowBus.wrData = arrWdata;
   assign rowBus.clearAll = state_q == ST_IDLE;
   // Read back the byte last strobed toward the array
   assign rowBus.rdIdx = aAddr_q[ROW_AW-1:0];

   fper_row_mem u_rowMem (
      .clk(clk),
      .rstn(rstn),
      .rowBus(rowBus)
   );

   // Byte program strobe toward the array
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         aAddr_q <= 16'h0000;
         aData_q <= 8'h00;
         aStrobe_q <= 1'b0;
      end
      else
      begin
         aStrobe_q <= rowBus.wrEn;
         if (rowBus.wrEn)
         begin
            aAddr_q <= arrAddr;
            aData_q <= arrWdata;
         end
      end
   end

   // Register read data, one cycle after the read strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (regRd)
      begin
         case (regAddr)
            REG_CTRL: rdata_q <= {4'h0, hvOn_q, wholeSel_q, wipeSel_q,
               writeSel_q};
            REG_PROT: rdata_q <= prot_q;
            REG_STAT: rdata_q <= {4'h0, rowFail_q, latProt,
               protRead_q, state_q == ST_STANDBY};
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end
   assign regRdata = rdata_q;

   // Array controls, all inactive in standby; high voltage only in ST_HIGHV
   assign aHighVolt = hvOn_q && state_q == ST_HIGHV;
   assign aWrite = writeSel_q && state_q != ST_STANDBY;
   assign aWipe = wipeSel_q && state_q != ST_STANDBY;
   assign aWhole = wholeSel_q && state_q != ST_STANDBY;
   assign aAddr = aAddr_q;
   assign aData = aData_q;
   assign aStrobe = aStrobe_q;
   assign rowFail = rowFail_q;

   a_select_lock: assert property (@(posedge clk)
      disable iff (!rstn) !(writeSel_q && wipeSel_q))
      else $error("selects both set");
   a_hv_gate: assert property (@(posedge clk)
      disable iff (!rstn) $rose(hvOn_q) |->
      $past(state_q) == ST_LATCHED && $past(protRead_q))
      else $error("high voltage without sequence");
   a_hv_protect: assert property (@(posedge clk)
      disable iff (!rstn) $rose(hvOn_q) |-> !$past(latProt))
      else $error("high voltage in protected range");
   a_standby_off: assert property (@(posedge clk)
      disable iff (!rstn) state_q == ST_STANDBY |->
      !aHighVolt && !aWrite && !aWipe && !aWhole)
      else $error("controls active in standby");
   a_lowpow_susp: assert property (@(posedge clk)
      disable iff (!rstn) state_q == ST_HIGHV && lowPower |=>
      state_q == ST_STANDBY) else $error("low power did not suspend");
   a_row_fail: assert property (@(posedge clk)
      disable iff (!rstn)
      state_q == ST_HIGHV && writeSel_q && arrWr && !sameRow |=> rowFail_q)
      else $error("cross row write not flagged");
   a_idle_lowpow: assert property (@(posedge clk)
      disable iff (!rstn) state_q == ST_IDLE && lowPower |=>
      state_q != ST_STANDBY) else $error("idle array suspended");
   a_prot_start: assert property (@(posedge clk)
      disable iff (!rstn) protStart[15] == 1'b0 && protStart[6:0] == 7'h00)
      else $error("protect start misaligned");
   a_strobe_lat: assert property (@(posedge clk)
      disable iff (!rstn) rowBus.wrEn |=> aStrobe
      && aAddr[15:ROW_SHIFT] == latAddr_q[15:ROW_SHIFT])
      else $error("strobe off row");
   a_row_back: assert property (@(posedge clk)
      disable iff (!rstn) aStrobe |=> rowBus.rdData == $past(aData))
      else $error("row latch readback wrong");
endmodule : fper_seq

// file: verilog/fper_pkg.sv
// Package of constants and types for the flash program/erase sequencer
package fper_pkg;
   // Register indices on the plain register port (one word each)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_PROT = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   // Control register field positions
   localparam int CTRL_HV = 3;
   localparam int CTRL_WHOLE = 2;
   localparam int CTRL_WIPE = 1;
   localparam int CTRL_WRITE = 0;
   // Reset values
   localparam logic [7:0] PROT_RESET = 8'hFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Row and page geometry
   localparam int ROW_BYTES = 64;
   localparam int ROW_SHIFT = 6;
   localparam int PAGE_SHIFT = 7;
   localparam int PROT_LSB = 7;
   localparam logic [15:0] ARRAY_END = 16'h7FFF;
   // Array address range
   localparam logic [15:0] ARRAY_LO = 16'h0462;
   // Row latch index width
   localparam int ROW_AW = 6;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_LATCHED, ST_HIGHV, ST_STANDBY
   } fper_state_t;
endpackage : fper_pkg

// file: verilog/fper_row_if.sv
// Interface between the sequencer and its row latch memory
`timescale 1ns/1ps
interface fper_row_if;
   logic wrEn;
   logic [5:0] wrIdx;
   logic [7:0] wrData;
   logic clearAll;
   logic [5:0] rdIdx;
   logic [7:0] rdData;
   modport seq (output wrEn, wrIdx, wrData, clearAll, rdIdx, input rdData);
   modport mem (input wrEn, wrIdx, wrData, clearAll, rdIdx, output rdData);
endinterface : fper_row_if

// file: verilog/fper_row_mem.sv
// Row data latch memory, 64 bytes, registered read data
`timescale 1ns/1ps
module fper_row_mem
   import fper_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   fper_row_if.mem rowBus
);
   // Latched bytes, erased value when unwritten
   logic [7:0] mem_q [ROW_BYTES];
   // Registered read port
   logic [7:0] rdData_q;

   // Per-entry latch update
   genvar gi;
   generate
      for (gi = 0; gi < ROW_BYTES; gi++) begin : g_ent
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               mem_q[gi] <= ERASED_BYTE;
            else if (rowBus.clearAll)
               mem_q[gi] <= ERASED_BYTE;
            else if (rowBus.wrEn && rowBus.wrIdx == 6'(gi))
               mem_q[gi] <= rowBus.wrData;
         end
      end
   endgenerate

   // Read data register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdData_q <= ERASED_BYTE;
      else
         rdData_q <= mem_q[rowBus.rdIdx];
   end
   assign rowBus.rdData = rdData_q;
endmodule : fper_row_mem

// file: tb/tb_top.sv
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
module tb_top
   import fper_pkg::*;
;
   logic clk, rstn, regWr, regRd, arrWr, waitMode, stopMode;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata, arrWdata, aData, rd;
   logic [15:0] arrAddr, aAddr;
   logic aHighVolt, aWrite, aWipe, aWhole, aStrobe, rowFail;
   int num_errors = 0;
   int samples_checked = 0;
   // Device under test
   fper_seq dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .arrWr(arrWr), .arrAddr(arrAddr),
      .arrWdata(arrWdata), .waitMode(waitMode), .stopMode(stopMode),
      .aHighVolt(aHighVolt), .aWrite(aWrite), .aWipe(aWipe),
      .aWhole(aWhole), .aAddr(aAddr), .aData(aData), .aStrobe(aStrobe),
      .rowFail(rowFail));
   // Clock, 100 ns period
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk
   // One-cycle register write
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask : reg_wr
   // One-cycle register read, data taken in the following cycle
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      rd = regRdata;
   endtask : reg_rd
   // One-cycle array write
   task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      arrAddr <= a;
      arrWdata <= d;
      arrWr <= 1'b1;
      @(posedge clk);
      arrWr <= 1'b0;
      #1;
   endtask : arr_wr
   // Select, protect read, row or page latch, then high voltage
   task automatic arm(input logic [7:0] sel, input logic [15:0] a);
      reg_wr(REG_CTRL, sel);
      reg_rd(REG_PROT);
      arr_wr(a, 8'hff);
      reg_wr(REG_CTRL, sel | 8'h08);
   endtask : arm
   // Reset values and an unmapped index
   task automatic t_reset();
      reg_rd(REG_PROT);
      chk("prot reset", 16'(PROT_RESET), 16'(rd));
      reg_rd(REG_CTRL);
      chk("ctrl reset", 16'(CTRL_RESET), 16'(rd));
      reg_rd(4'h3);
      chk("unmapped", 16'h0000, 16'(rd));
   endtask : t_reset
   // Write and wipe selects never both set
   task automatic t_interlock();
      reg_wr(REG_CTRL, 8'h01);
      reg_wr(REG_CTRL, 8'h03);
      reg_rd(REG_CTRL);
      chk("ctrl held", 16'h0001, 16'(rd));
      chk("wipe out", 16'h0000, 16'(aWipe));
      reg_wr(REG_CTRL, 8'h00);
      reg_wr(REG_CTRL, 8'h03);
      reg_rd(REG_CTRL);
      chk("ctrl both", 16'h0002, 16'(rd));
      reg_wr(REG_CTRL, 8'h06);
      chk("whole sel", 16'h0001, 16'(aWhole));
      reg_wr(REG_CTRL, 8'h00);
   endtask : t_interlock
   // High voltage refused out of sequence
   task automatic t_refuse();
      reg_wr(REG_CTRL, 8'h01);
      reg_wr(REG_CTRL, 8'h09);
      chk("hv no latch", 16'h0000, 16'(aHighVolt));
      // Array write without the protect read must not arm
      arr_wr(16'h1e40, 8'hff);
      reg_wr(REG_CTRL, 8'h09);
      chk("hv no prot read", 16'h0000, 16'(aHighVolt));
      reg_wr(REG_CTRL, 8'h00);
      reg_wr(REG_CTRL, 8'h08);
      chk("hv no select", 16'h0000, 16'(aHighVolt));
      reg_wr(REG_CTRL, 8'h00);
   endtask : t_refuse
   // Row program with a byte at the row end, then a cross-row write
   task automatic t_program();
      arm(8'h01, 16'h1e40);
      chk("hv prog", 16'h0001, 16'(aHighVolt));
      chk("write sel", 16'h0001, 16'(aWrite));
      arr_wr(16'h1e7f, 8'h5a);
      chk("strobe", 16'h0001, 16'(aStrobe));
      chk("byte addr", 16'h1e7f, aAddr);
      chk("byte data", 16'h005a, 16'(aData));
      chk("same row", 16'h0000, 16'(rowFail));
      arr_wr(16'h1e80, 8'h33);
      chk("cross row", 16'h0001, 16'(rowFail));
      chk("no strobe", 16'h0000, 16'(aStrobe));
      reg_wr(REG_CTRL, 8'h08);
      chk("write off", 16'h0000, 16'(aWrite));
      reg_wr(REG_CTRL, 8'h00);
      chk("hv off", 16'h0000, 16'(aHighVolt));
   endtask : t_program
   // Page erase
   task automatic t_erase();
      arm(8'h02, 16'h2000);
      chk("fail clear", 16'h0000, 16'(rowFail));
      chk("hv erase", 16'h0001, 16'(aHighVolt));
      chk("wipe sel", 16'h0001, 16'(aWipe));
      chk("page mode", 16'h0000, 16'(aWhole));
      // Shortened erase pulse; the bench keeps no wear count
      repeat (40) @(posedge clk);
      #1;
      chk("hv held", 16'h0001, 16'(aHighVolt));
      reg_wr(REG_CTRL, 8'h08);
      chk("wipe off", 16'h0000, 16'(aWipe));
      reg_wr(REG_CTRL, 8'h00);
   endtask : t_erase
   // Protected range starts at page 0x1f80
   task automatic t_protect();
      reg_wr(REG_PROT, 8'h3f);
      reg_rd(REG_PROT);
      chk("prot val", 16'h003f, 16'(rd));
      arm(8'h01, 16'h1f80);
      chk("hv guarded", 16'h0000, 16'(aHighVolt));
      reg_rd(REG_STAT);
      chk("stat guarded", 16'h0006, 16'(rd));
      reg_wr(REG_CTRL, 8'h00);
      arm(8'h01, 16'h1f7f);
      chk("hv below", 16'h0001, 16'(aHighVolt));
      reg_wr(REG_CTRL, 8'h08);
      reg_wr(REG_CTRL, 8'h00);
      reg_wr(REG_PROT, 8'hff);
   endtask : t_protect
   // Wait and stop during an operation, then wait while idle
   task automatic t_lowpower();
      for (int m = 0; m < 2; m++)
      begin
         arm(8'h01, 16'h1e40);
         @(posedge clk);
         waitMode <= (m == 0);
         stopMode <= (m == 1);
         repeat (2) @(posedge clk);
         #1;
         chk("hv standby", 16'h0000, 16'(aHighVolt));
         chk("write standby", 16'h0000, 16'(aWrite));
         reg_rd(REG_STAT);
         chk("standby flag", 16'h0001, 16'(rd[0]));
         @(posedge clk);
         waitMode <= 1'b0;
         stopMode <= 1'b0;
         reg_wr(REG_CTRL, 8'h00);
         reg_rd(REG_STAT);
         chk("standby exit", 16'h0000, 16'(rd[0]));
      end
      @(posedge clk);
      waitMode <= 1'b1;
      reg_rd(REG_STAT);
      chk("idle standby", 16'h0000, 16'(rd[0]));
      reg_rd(REG_PROT);
      chk("idle read", 16'h00ff, 16'(rd));
      @(posedge clk);
      waitMode <= 1'b0;
   endtask : t_lowpower
   // Counts and verdict
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      rstn = 1'b0;
      {regWr, regRd, arrWr, waitMode, stopMode} = '0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      arrAddr = 16'h0000;
      arrWdata = 8'h00;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_interlock();
      t_refuse();
      t_program();
      t_erase();
      t_protect();
      t_lowpower();
      give_verdict();
   end
endmodule : tb_top
